// File: src/err_flag.sv
`default_nettype none
// one sticky error flag: set wins over clear
module err_flag (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic set_en,
	input  wire logic clr_en,
	output logic      flag
);
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			flag <= 1'b0;
		end else if (ce) begin
			if (set_en)
				flag <= 1'b1;
			else if (clr_en)
				flag <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: src/serial_ctrl_pkg.sv
`default_nettype none
package serial_ctrl_pkg;
	// ----------------------------------------
	// register index (printed offsets are word indices; byte address is four times the index)
	// ----------------------------------------
	localparam logic [9:0]  ctrl_one_idx     = 10'h0a5;
	localparam logic [9:0]  rx_word_idx      = 10'h0a6;
	localparam logic [9:0]  irq_status_idx   = 10'h0a8;
	localparam logic [9:0]  irq_mask_idx     = 10'h0a9;
	localparam logic [9:0]  mode_idx         = 10'h0aa;
	localparam int          addr_w           = 12;
	localparam logic [11:0] ctrl_one_addr    = {ctrl_one_idx, 2'b00};
	localparam logic [11:0] rx_word_addr     = {rx_word_idx, 2'b00};
	localparam logic [11:0] irq_status_addr  = {irq_status_idx, 2'b00};
	localparam logic [11:0] irq_mask_addr    = {irq_mask_idx, 2'b00};
	localparam logic [11:0] mode_addr        = {mode_idx, 2'b00};
	// ----------------------------------------
	// control register fields
	// ----------------------------------------
	localparam int tx_permit_bit   = 0;
	localparam int tx_empty_bit    = 1;
	localparam int rx_permit_bit   = 2;
	localparam int rx_full_bit     = 3;
	localparam int tx_irq_sel_bit  = 4;
	localparam int cont_rx_bit     = 5;
	// ----------------------------------------
	// receive word fields
	// ----------------------------------------
	localparam int data_msb        = 8;
	localparam int overrun_bit     = 12;
	localparam int framing_bit     = 13;
	localparam int parity_bit      = 14;
	localparam int summary_bit     = 15;
	localparam int overrun_data_bit = 7;
	// ----------------------------------------
	// mode field and reset values
	// ----------------------------------------
	localparam logic [2:0] mode_disabled   = 3'h0;
	localparam logic [2:0] mode_sync       = 3'h1;
	localparam logic [2:0] mode_reset      = 3'h0;
	localparam logic       tx_empty_reset  = 1'b1;
	localparam logic       rx_full_reset   = 1'b0;
	localparam logic       cont_rx_reset   = 1'b0;
	localparam logic [3:0] irq_mask_reset  = 4'h0;
	// irq status bits
	localparam int irq_tx_bit      = 0;
	localparam int irq_rx_bit      = 1;
	localparam int irq_err_bit     = 2;
endpackage
`default_nettype wire

// File: src/serial_ctrl_rx_buffer_status.sv
// The address-and-strobe port was chosen for this implementation.
`default_nettype none
// Functional notes
// RULE1 - control b1 reads 0 while tx holding word waits, 1 when empty; resets 1
// RULE2 - control b3 reads 1 while rx holding word unread; resets 0
// RULE3 - reading upper byte of rx holding word clears receive-complete flag
// RULE4 - b4 picks tx irq: 0 holding empty, 1 shift register finished
// RULE5 - b5 continuous receive enable, read/write, resets 0
// RULE6 - software keeps continuous receive at 0 in asynchronous mode
// RULE7 - software rewrites baud divider after changing its count source
// RULE8 - rx word b0-b7 data bits 7..0, b8 data bit 8
// RULE9 - overrun b12, framing b13, parity b14, summary b15, read-only
// RULE10 - all error flags cleared when mode disabled or rx permit is 0
// RULE11 - summary flag is 0 exactly when other three flags are 0
// RULE12 - reading upper byte also clears framing and parity flags
// RULE13 - software clears both permit bits before disabling the mode
// RULE14 - framing, parity and summary undefined in clock-synchronous mode
// RULE15 - software reads the rx holding word as one 16-bit access
// RULE16 - control bits b6 and b7 read 0
// RULE17 - shift-empty flag 0 while word in shift register, 1 when done
// RULE18 - overrun when new word starts unread and its 7th bit arrives
// RULE19 - receive-complete set when finished word moves into holding word
module serial_ctrl_rx_buffer_status
	import serial_ctrl_pkg::*;
(
	input  wire logic                         mclk,
	input  wire logic                         rst,
	input  wire logic                         ce,
	input  wire logic [serial_ctrl_pkg::addr_w-1:0] addr,
	input  wire logic [15:0]                  wdata,
	input  wire logic                         wr,
	input  wire logic                         rd,
	output logic      [15:0]                  rdata,
	output logic                              irq,
	// engine side
	input  wire logic                         tx_load,
	input  wire logic                         tx_start,
	input  wire logic                         tx_done,
	input  wire logic                         rx_bit_tick,
	input  wire logic [2:0]                   rx_bit_idx,
	input  wire logic                         rx_word_done,
	input  wire logic [8:0]                   rx_data,
	input  wire logic                         rx_framing_err,
	input  wire logic                         rx_parity_err,
	output logic                              transmit_permit,
	output logic                              rx_permit,
	output logic                              continuous_rx_mode,
	output logic [2:0]                        serial_mode_field
);
	import serial_ctrl_pkg::*;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	wire hit_ctrl   = addr == ctrl_one_addr;
	wire hit_rxw    = addr == rx_word_addr;
	wire hit_ists   = addr == irq_status_addr;
	wire hit_imsk   = addr == irq_mask_addr;
	wire hit_mode   = addr == mode_addr;
	wire wr_ctrl    = ce && wr && hit_ctrl;
	wire wr_ists    = ce && wr && hit_ists;
	wire wr_imsk    = ce && wr && hit_imsk;
	wire wr_mode    = ce && wr && hit_mode;
	// a word read covers the upper byte, so it clears unless a word is accepted in the same cycle
	wire rd_rxw     = ce && rd && hit_rxw;

	// ----------------------------------------
	// control state
	// ----------------------------------------
	logic       tx_permit_r, tx_permit_nxt;
	logic       rx_permit_r, rx_permit_nxt;
	logic       tx_irq_sel_r, tx_irq_sel_nxt;
	logic       cont_rx_r, cont_rx_nxt;
	logic [2:0] mode_r, mode_nxt;
	logic       tx_empty_r, shift_empty_r, rx_full_r;
	logic [8:0] rx_data_r;
	logic [3:0] ists_r, imsk_r;
	logic       rx_busy_r;

	assign tx_permit_nxt  = wr_ctrl ? wdata[tx_permit_bit] : tx_permit_r;
	assign rx_permit_nxt  = wr_ctrl ? wdata[rx_permit_bit] : rx_permit_r;
	assign tx_irq_sel_nxt = wr_ctrl ? wdata[tx_irq_sel_bit] : tx_irq_sel_r;
	assign cont_rx_nxt    = wr_ctrl ? wdata[cont_rx_bit] : cont_rx_r; // RULE5
	assign mode_nxt       = wr_mode ? wdata[2:0] : mode_r;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tx_permit_r  <= 1'b0;
			rx_permit_r  <= 1'b0;
			tx_irq_sel_r <= 1'b0;
			cont_rx_r    <= cont_rx_reset; // RULE5
			mode_r       <= mode_reset;
			imsk_r       <= irq_mask_reset;
		end else if (ce) begin
			tx_permit_r  <= tx_permit_nxt;
			rx_permit_r  <= rx_permit_nxt;
			tx_irq_sel_r <= tx_irq_sel_nxt;
			cont_rx_r    <= cont_rx_nxt;
			mode_r       <= mode_nxt;
			if (wr_imsk)
				imsk_r <= wdata[3:0];
		end
	end

	// ----------------------------------------
	// transmit buffer and shift flags
	// ----------------------------------------
	// load fills the holding word, start moves it into the shifter
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tx_empty_r    <= tx_empty_reset; // RULE1
			shift_empty_r <= 1'b1;
		end else if (ce) begin
			if (tx_load)
				tx_empty_r <= 1'b0; // RULE1
			else if (tx_start)
				tx_empty_r <= 1'b1; // RULE1
			if (tx_start)
				shift_empty_r <= 1'b0; // RULE17
			else if (tx_done)
				shift_empty_r <= 1'b1; // RULE17
		end
	end

	// ----------------------------------------
	// receive holding word
	// ----------------------------------------
	wire rx_accept = rx_word_done && rx_permit_r;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rx_full_r <= rx_full_reset; // RULE2
			rx_data_r <= 9'h000;
			rx_busy_r <= 1'b0;
		end else if (ce) begin
			if (rx_accept) begin
				rx_full_r <= 1'b1; // RULE19
				rx_data_r <= rx_data; // RULE8
			end else if (rd_rxw) begin
				rx_full_r <= 1'b0; // RULE3
			end
			// a word is in flight between its first bit and its transfer
			if (rx_word_done)
				rx_busy_r <= 1'b0;
			else if (rx_bit_tick && rx_permit_r)
				rx_busy_r <= 1'b1;
		end
	end

	// ----------------------------------------
	// error flags
	// ----------------------------------------
	logic ovr_f, frm_f, par_f;
	wire  err_wipe  = (mode_r == mode_disabled) || !rx_permit_r; // RULE10
	// overrun: 7th bit of a new word lands on an unread holding word
	wire  ovr_set   = rx_bit_tick && rx_permit_r && rx_full_r && rx_busy_r
			&& rx_bit_idx == 3'(overrun_data_bit - 1); // RULE18
	wire  frm_set   = rx_accept && rx_framing_err;
	wire  par_set   = rx_accept && rx_parity_err;
	wire  rd_clr    = rd_rxw || err_wipe; // RULE12

	err_flag u_ovr (
		.mclk   (mclk),
		.rst    (rst),
		.ce     (ce),
		.set_en (ovr_set && !err_wipe),
		.clr_en (err_wipe), // RULE10
		.flag   (ovr_f)
	);
	err_flag u_frm (
		.mclk   (mclk),
		.rst    (rst),
		.ce     (ce),
		.set_en (frm_set && !err_wipe),
		.clr_en (rd_clr), // RULE12
		.flag   (frm_f)
	);
	err_flag u_par (
		.mclk   (mclk),
		.rst    (rst),
		.ce     (ce),
		.set_en (par_set && !err_wipe),
		.clr_en (rd_clr), // RULE12
		.flag   (par_f)
	);

	// in synchronous mode framing/parity are simply never set by the engine
	wire sum_f = ovr_f | frm_f | par_f; // RULE11 RULE14

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	wire tx_src  = tx_irq_sel_r ? (tx_done && !shift_empty_r)
			: tx_start; // RULE4
	wire [3:0] ev = {1'b0, ovr_set | frm_set | par_set, rx_accept, tx_src};
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			ists_r <= 4'h0;
		else if (ce)
			// set wins over write-one-to-clear
			ists_r <= (ists_r & ~(wr_ists ? wdata[3:0] : 4'h0)) | ev;
	end
	assign irq = |(ists_r & imsk_r);

	// ----------------------------------------
	// read path
	// ----------------------------------------
	wire [15:0] ctrl_rd = {8'h00, 2'b00, cont_rx_r, tx_irq_sel_r, // RULE16
			rx_full_r, rx_permit_r, tx_empty_r, tx_permit_r}; // RULE1 RULE2
	wire [15:0] rxw_rd  = {sum_f, par_f, frm_f, ovr_f, 3'b000,
			rx_data_r}; // RULE8 RULE9
	wire [15:0] rd_mux  = hit_ctrl ? ctrl_rd
			: hit_rxw  ? rxw_rd
			: hit_ists ? {12'h000, ists_r}
			: hit_imsk ? {12'h000, imsk_r}
			: hit_mode ? {13'h0000, mode_r}
			: 16'h0000;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			rdata <= 16'h0000;
		else if (ce && rd)
			rdata <= rd_mux;
	end

	assign transmit_permit    = tx_permit_r;
	assign rx_permit          = rx_permit_r;
	assign continuous_rx_mode = cont_rx_r;
	assign serial_mode_field  = mode_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_rx_full_clear: assert property (@(posedge mclk) disable iff (rst) // RULE3
		ce && rd_rxw && !rx_accept |=> !rx_full_r)
		else $error("rx full flag not cleared by read");
	a_rx_full_set: assert property (@(posedge mclk) disable iff (rst) // RULE19
		ce && rx_accept |=> rx_full_r && rx_data_r == $past(rx_data))
		else $error("holding word not loaded");
	a_err_wipe_all: assert property (@(posedge mclk) disable iff (rst) // RULE10
		ce && err_wipe ##1 ce && err_wipe |-> !ovr_f && !frm_f && !par_f)
		else $error("error flags survive disable");
	a_sum_matches: assert property (@(posedge mclk) disable iff (rst) // RULE11
		ce && rd && hit_rxw
		|=> rdata[summary_bit] == |rdata[parity_bit:overrun_bit])
		else $error("summary flag mismatch");
	a_read_clears_fp: assert property (@(posedge mclk) disable iff (rst) // RULE12
		ce && rd_rxw && !frm_set && !par_set |=> !frm_f && !par_f)
		else $error("framing or parity not cleared by read");
	a_tx_empty_flag: assert property (@(posedge mclk) disable iff (rst) // RULE1
		ce && tx_load |=> ctrl_rd[tx_empty_bit] == 1'b0)
		else $error("tx empty flag not dropped on load");
	a_ctrl_upper_zero: assert property (@(posedge mclk) disable iff (rst) // RULE16
		ce && rd && hit_ctrl |=> rdata[7:6] == 2'b00)
		else $error("control bits 7:6 not zero");
	a_overrun_catch: assert property (@(posedge mclk) disable iff (rst) // RULE18
		ce && ovr_set && !err_wipe |=> ovr_f)
		else $error("overrun not flagged");
	a_shift_empty: assert property (@(posedge mclk) disable iff (rst) // RULE17
		ce && tx_start |=> !shift_empty_r)
		else $error("shift empty not cleared on start");
	a_tx_irq_src: assert property (@(posedge mclk) disable iff (rst) // RULE4
		ce && !tx_irq_sel_r && tx_start |=> ists_r[irq_tx_bit])
		else $error("tx irq not raised on holding empty");
	a_cont_rx_wr: assert property (@(posedge mclk) disable iff (rst) // RULE5
		wr_ctrl |=> cont_rx_r == $past(wdata[cont_rx_bit]))
		else $error("continuous rx bit not written");
	a_tx_empty_start: assert property (@(posedge mclk) disable iff (rst) // RULE1
		ce && tx_start && !tx_load |=> tx_empty_r)
		else $error("tx empty flag not set on start");
	a_tx_empty_ro: assert property (@(posedge mclk) disable iff (rst) // RULE1
		wr_ctrl && !tx_load && !tx_start |=> tx_empty_r == $past(tx_empty_r))
		else $error("tx empty flag moved by a write");
	a_rx_full_read: assert property (@(posedge mclk) disable iff (rst) // RULE2
		ce && rd && hit_ctrl |=> rdata[rx_full_bit] == $past(rx_full_r))
		else $error("rx full flag misread");
	a_tx_irq_done: assert property (@(posedge mclk) disable iff (rst) // RULE4
		ce && tx_irq_sel_r && tx_done && !shift_empty_r |=> ists_r[irq_tx_bit])
		else $error("tx irq not raised on shift done");
	a_cont_rx_read: assert property (@(posedge mclk) disable iff (rst) // RULE5
		ce && rd && hit_ctrl |=> rdata[cont_rx_bit] == $past(cont_rx_r))
		else $error("continuous rx bit misread");
	a_rx_data_read: assert property (@(posedge mclk) disable iff (rst) // RULE8
		ce && rd && hit_rxw |=> rdata[data_msb:0] == $past(rx_data_r))
		else $error("rx data misread");
	a_err_read_only: assert property (@(posedge mclk) disable iff (rst) // RULE9
		ce && wr && hit_rxw && !ovr_set && !frm_set && !par_set
		&& !err_wipe && !rd
		|=> {ovr_f, frm_f, par_f} == $past({ovr_f, frm_f, par_f}))
		else $error("error flags moved by a write");
	a_err_wipe_now: assert property (@(posedge mclk) disable iff (rst) // RULE10
		ce && err_wipe |=> !ovr_f && !frm_f && !par_f)
		else $error("error flags not wiped at once");
	a_ovr_keeps: assert property (@(posedge mclk) disable iff (rst) // RULE12
		ce && rd_rxw && ovr_f && !err_wipe |=> ovr_f)
		else $error("overrun cleared by a read");
	a_shift_done: assert property (@(posedge mclk) disable iff (rst) // RULE17
		ce && tx_done && !tx_start |=> shift_empty_r)
		else $error("shift empty not set on done");
	a_ovr_hold: assert property (@(posedge mclk) disable iff (rst) // RULE18
		ce && !ovr_set && !err_wipe |=> ovr_f == $past(ovr_f))
		else $error("overrun flag moved with no cause");
	a_rx_drop_off: assert property (@(posedge mclk) disable iff (rst) // RULE19
		ce && rx_word_done && !rx_permit_r && !rd_rxw
		|=> rx_full_r == $past(rx_full_r))
		else $error("word taken while reception off");
endmodule
`default_nettype wire

// File: test/serial_ctrl_rx_buffer_status_tb.sv
`default_nettype none
module serial_ctrl_rx_buffer_status_tb import serial_ctrl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk, rst, wr, rd, rd_d, irq;
	logic        ce, tx_perm, rx_perm, cont_rx;
	logic [11:0] addr;
	logic [15:0] wdata, rdata;
	logic        tx_load, tx_start, tx_done, rx_bit_tick, rx_word_done;
	logic        rx_framing_err, rx_parity_err;
	logic [2:0]  rx_bit_idx, mode_f;
	logic [8:0]  rx_data, d;
	logic [15:0] exp_q[$];
	int          bad_count, tests_run, seed;

	serial_ctrl_rx_buffer_status dut (
		.mclk(mclk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .tx_load(tx_load),
		.tx_start(tx_start), .tx_done(tx_done), .rx_bit_tick(rx_bit_tick),
		.rx_bit_idx(rx_bit_idx), .rx_word_done(rx_word_done),
		.rx_data(rx_data), .rx_framing_err(rx_framing_err),
		.rx_parity_err(rx_parity_err), .transmit_permit(tx_perm),
		.rx_permit(rx_perm), .continuous_rx_mode(cont_rx),
		.serial_mode_field(mode_f)
	);
	serial_engine_model pm (
		.mclk(mclk), .tx_load(tx_load), .tx_start(tx_start),
		.tx_done(tx_done), .rx_bit_tick(rx_bit_tick),
		.rx_bit_idx(rx_bit_idx), .rx_word_done(rx_word_done),
		.rx_data(rx_data), .rx_framing_err(rx_framing_err),
		.rx_parity_err(rx_parity_err)
	);

	always #5 mclk = ~mclk;
	always @(posedge mclk) rd_d <= rd;
	// read data appear in the cycle after the strobe and hold until the next read
	always @(negedge mclk) begin
		if (rd_d === 1'b1) begin
			cmp(rdata, exp_q.pop_front());
		end
	end

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [15:0] v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wr <= w;
		rd <= ~w;
		@(posedge mclk);
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 16'h0000);
	endtask
	task automatic irq_chk(input logic e);
		@(negedge mclk);
		cmp({15'h0000, irq}, {15'h0000, e});
	endtask
	// control outputs: transmit, receive, continuous, mode field
	task automatic pins_chk(input logic [5:0] e);
		@(negedge mclk);
		cmp({10'h000, tx_perm, rx_perm, cont_rx, mode_f}, {10'h000, e});
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge mclk);
		bad_count++;
		tally_and_finish;
	end

	initial begin
		{mclk, rst, wr, rd, addr, wdata} = {2'b01, 2'b00, 28'h0000000};
		{bad_count, tests_run, seed} = {32'd0, 32'd0, 32'd13};
		ce = 1'b1;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		rdc(ctrl_one_addr, 16'h0002);
		rdc(irq_mask_addr, 16'h0000);
		bus(1'b1, 12'hffc, 16'hffff);
		rdc(12'hffc, 16'h0000);
		// continuous receive only outside asynchronous frames
		bus(1'b1, mode_addr, {13'h0000, mode_sync});
		bus(1'b1, ctrl_one_addr, 16'h0020);
		rdc(ctrl_one_addr, 16'h0022);
		pins_chk(6'h09);
		bus(1'b1, ctrl_one_addr, 16'h0000);
		// count source never changes here, so no divider rewrite is owed
		bus(1'b1, mode_addr, 16'h0002);
		bus(1'b1, ctrl_one_addr, 16'h00c5);
		rdc(ctrl_one_addr, 16'h0007);
		pins_chk(6'h32);
		bus(1'b1, irq_mask_addr, 16'h0007);
		pm.tx_pulse(3'h1);
		rdc(ctrl_one_addr, 16'h0005);
		pm.tx_pulse(3'h2);
		rdc(ctrl_one_addr, 16'h0007);
		rdc(irq_status_addr, 16'h0001);
		irq_chk(1'b1);
		pm.tx_pulse(3'h4);
		bus(1'b1, irq_status_addr, 16'h0001);
		rdc(irq_status_addr, 16'h0000);
		irq_chk(1'b0);
		bus(1'b1, ctrl_one_addr, 16'h0015);
		pm.tx_pulse(3'h1);
		pm.tx_pulse(3'h2);
		rdc(irq_status_addr, 16'h0000);
		pm.tx_pulse(3'h4);
		rdc(irq_status_addr, 16'h0001);
		bus(1'b1, irq_mask_addr, 16'h0000);
		irq_chk(1'b0);
		bus(1'b1, irq_status_addr, 16'h0007);
		bus(1'b1, irq_mask_addr, 16'h0007);
		d = 9'($random(seed));
		pm.rx_word(d, 1'b1, 1'b0);
		rdc(ctrl_one_addr, 16'h001f);
		irq_chk(1'b1);
		// whole-word reads only
		rdc(rx_word_addr, {7'h50, d});
		rdc(ctrl_one_addr, 16'h0017);
		rdc(rx_word_addr, {7'h00, d});
		d = 9'($random(seed));
		pm.rx_word(d, 1'b0, 1'b1);
		rdc(rx_word_addr, {7'h60, d});
		d = 9'($random(seed));
		pm.rx_word(d, 1'b0, 1'b0);
		for (int i = 0; i < 7; i++) begin
			pm.rx_bit(3'(i));
		end
		rdc(rx_word_addr, {7'h48, d});
		bus(1'b1, ctrl_one_addr, 16'h0011);
		rdc(rx_word_addr, {7'h00, d});
		pm.rx_word(~d, 1'b1, 1'b1);
		rdc(ctrl_one_addr, 16'h0013);
		// frozen clock enable: neither bus nor engine may move state
		@(posedge mclk) ce <= 1'b0;
		bus(1'b1, ctrl_one_addr, 16'($random(seed)));
		pm.tx_pulse(3'h1);
		@(posedge mclk) ce <= 1'b1;
		rdc(ctrl_one_addr, 16'h0013);
		pins_chk(6'h22);
		// both permits drop before the mode is switched off
		bus(1'b1, ctrl_one_addr, 16'h0000);
		bus(1'b1, mode_addr, 16'h0000);
		rdc(mode_addr, 16'h0000);
		pins_chk(6'h00);
		repeat (2) @(posedge mclk);
		tally_and_finish;
	end
endmodule
`default_nettype wire

// File: test/serial_engine_model.sv
`default_nettype none
module serial_engine_model (
	input  wire logic  mclk,
	output logic       tx_load,
	output logic       tx_start,
	output logic       tx_done,
	output logic       rx_bit_tick,
	output logic [2:0] rx_bit_idx,
	output logic       rx_word_done,
	output logic [8:0] rx_data,
	output logic       rx_framing_err,
	output logic       rx_parity_err
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{tx_load, tx_start, tx_done, rx_bit_tick, rx_word_done} = 5'h00;
		{rx_bit_idx, rx_data, rx_framing_err, rx_parity_err} = 14'h0000;
	end
	// the caller keeps the order load, start, done
	task automatic tx_pulse(input logic [2:0] w);
		@(posedge mclk);
		{tx_done, tx_start, tx_load} <= w;
		@(posedge mclk);
		{tx_done, tx_start, tx_load} <= 3'h0;
	endtask
	task automatic rx_word(input logic [8:0] d, input logic fe, pe);
		@(posedge mclk);
		{rx_data, rx_framing_err, rx_parity_err} <= {d, fe, pe};
		rx_word_done <= 1'b1;
		@(posedge mclk);
		rx_word_done <= 1'b0;
		// qualifiers lapse: show the inverse, never a stale word
		{rx_data, rx_framing_err, rx_parity_err} <= ~{d, fe, pe};
	endtask
	task automatic rx_bit(input logic [2:0] i);
		@(posedge mclk);
		rx_bit_idx <= i;
		rx_bit_tick <= 1'b1;
		@(posedge mclk);
		rx_bit_tick <= 1'b0;
		rx_bit_idx <= ~i;
	endtask
endmodule
`default_nettype wire
